// [logic/fmd_pkg.sv]
// Constants and types shared by the film mode and motion detector
//------------------------------------------------------------------------------
// Function
// - Chroma conversion reuses the luminance motion vectors, no separate chroma estimate.
// - Filter select: 11 improved median, 10 median, 01 intrafield, 00 interfield.
// - Per field, sum absolute vector components above the minimum vector threshold.
// - Moving if sum above upper bound, or between bounds in camera mode.
// - Still if sum at most lower bound, or between bounds in film mode.
// - Scale setting maps 00 to 8, 01 to 16, 10 to 32, 11 to 64.
// - Mode switches only after condition held two times (history plus one) fields.
// - Provide global motion flag and a moving block count for the host.
// - Source field zero uses vector activity; nonzero uses field difference, 1 most sensitive.
// - A control bit inverts the film phase at the report output only.
// - Separate camera and film thresholds, one shared history length.
// - Detect film mode, type and phase; 50 Hz film moves every second field.
// - Global motion clears only after 32 consecutive still fields.
// - Film type reads one for 2-3 pulldown, zero for 25 phase sources.
//------------------------------------------------------------------------------
package fmd_pkg;
    // Widths
    localparam int VEC_W       = 8;
    localparam int SUM_W       = 20;
    localparam int BOUND_W     = 16;
    localparam int STAT_W      = 8;
    localparam int HIST_CNT_W  = 6;
    localparam int STILL_CNT_W = 6;

    // Reset values
    localparam logic                   MODE_RST   = 1'b0;
    localparam logic                   GMOT_RST   = 1'b1;
    localparam logic                   TYPE_RST   = 1'b0;
    localparam logic                   PHASE_RST  = 1'b0;
    localparam logic [SUM_W-1:0]       SUM_RST    = 20'h00000;
    localparam logic [STAT_W-1:0]      STAT_RST   = 8'h00;

    // Scale factor 8 is a left shift by three, each code step doubles it
    localparam logic [3:0]             SCALE_BASE_SHIFT = 4'h3;

    // Still fields in a row that clear the global motion flag
    localparam logic [STILL_CNT_W-1:0] STILL_FIELDS = 6'h20;

    // Field difference threshold is the source code shifted left by this many bits
    localparam int                     FDIFF_SHIFT = 4;

    // Interpolation filter codes
    localparam logic [1:0] FILT_IMPROVED = 2'h3;
    localparam logic [1:0] FILT_MEDIAN   = 2'h2;
    localparam logic [1:0] FILT_INTRA    = 2'h1;
    localparam logic [1:0] FILT_INTER    = 2'h0;

    // Detection source code that selects vector activity
    localparam logic [3:0] SRC_VECTOR = 4'h0;

    typedef enum logic {
        CAMERA_MODE = 1'b0,
        FILM_MODE   = 1'b1
    } film_camera_t;
endpackage

// [logic/activity_term.sv]
// Per-block activity term from a vector pair or a field difference sample
`timescale 1ns/1ns
`default_nettype none
module activity_term (
    // Selection and thresholds
    input  wire logic [3:0]               src_sel_in,
    input  wire logic [fmd_pkg::VEC_W-1:0] min_vector_threshold_in,
    // Vector sample
    input  wire logic                     vec_valid_in,
    input  wire logic [fmd_pkg::VEC_W-1:0] vec_x_in,
    input  wire logic [fmd_pkg::VEC_W-1:0] vec_y_in,
    // Field difference sample
    input  wire logic                     fdiff_valid_in,
    input  wire logic [fmd_pkg::VEC_W-1:0] fdiff_in,
    // Result
    output logic                          term_valid_out,
    output logic [fmd_pkg::VEC_W:0]       term_out,
    output logic                          block_moving_out
);
    wire                          use_vec  = (src_sel_in == fmd_pkg::SRC_VECTOR);
    // Magnitudes of two's complement components
    wire [fmd_pkg::VEC_W-1:0]     abs_x    = vec_x_in[fmd_pkg::VEC_W-1] ? -vec_x_in : vec_x_in;
    wire [fmd_pkg::VEC_W-1:0]     abs_y    = vec_y_in[fmd_pkg::VEC_W-1] ? -vec_y_in : vec_y_in;
    // Small vectors are noise, so only components above the threshold count
    wire [fmd_pkg::VEC_W-1:0]     keep_x   = (abs_x > min_vector_threshold_in) ? abs_x : '0;
    wire [fmd_pkg::VEC_W-1:0]     keep_y   = (abs_y > min_vector_threshold_in) ? abs_y : '0;
    wire [fmd_pkg::VEC_W:0]       vec_term = {1'b0, keep_x} + {1'b0, keep_y};
    // Larger source code raises the difference bar, so 1 is the most sensitive
    wire [fmd_pkg::VEC_W+3:0]     diff_bar = {src_sel_in, {fmd_pkg::FDIFF_SHIFT{1'b0}}, 4'h0};
    wire                          diff_mov = {4'h0, fdiff_in} > (diff_bar >> 4);

    // Source mux between vector activity and field difference
    assign term_valid_out   = use_vec ? vec_valid_in : fdiff_valid_in;
    assign term_out         = use_vec ? vec_term : {1'b0, fdiff_in};
    assign block_moving_out = use_vec ? (vec_term != '0) : diff_mov;
endmodule
`default_nettype wire

// [logic/film_mode_motion_detector.sv]
// Field motion, film mode, film type, film phase and global motion detector
`timescale 1ns/1ns
`default_nettype none
module film_mode_motion_detector (
    // Clock and reset
    input  wire logic                          ref_clk_in,
    input  wire logic                          rstn_in,
    // Field timing
    input  wire logic                          field_start_in,
    input  wire logic                          field_parity_in,
    // Luminance motion vectors, one pair per block
    input  wire logic                          vec_valid_in,
    input  wire logic [fmd_pkg::VEC_W-1:0]     vec_x_in,
    input  wire logic [fmd_pkg::VEC_W-1:0]     vec_y_in,
    // Field difference samples, one per block
    input  wire logic                          fdiff_valid_in,
    input  wire logic [fmd_pkg::VEC_W-1:0]     fdiff_in,
    // Configuration
    input  wire logic [fmd_pkg::VEC_W-1:0]     min_vector_threshold_in,
    input  wire logic [7:0]                    lower_motion_threshold_in,
    input  wire logic [7:0]                    upper_motion_threshold_in,
    input  wire logic [1:0]                    lower_scale_select_in,
    input  wire logic [1:0]                    upper_scale_select_in,
    input  wire logic [3:0]                    hysteresis_history_length_in,
    input  wire logic [3:0]                    detect_source_select_in,
    input  wire logic                          phase_invert_in,
    input  wire logic [1:0]                    interp_filter_select_in,
    // Interpolation filter choice, one hot
    output logic                               interp_improved_median_out,
    output logic                               interp_median_out,
    output logic                               interp_intrafield_out,
    output logic                               interp_interfield_out,
    // Chroma compensation vectors
    output logic                               chroma_vec_valid_out,
    output logic [fmd_pkg::VEC_W-1:0]          chroma_vec_x_out,
    output logic [fmd_pkg::VEC_W-1:0]          chroma_vec_y_out,
    // Detection results
    output logic                               field_done_out,
    output logic                               field_moving_out,
    output logic [fmd_pkg::SUM_W-1:0]          vector_activity_sum_out,
    output logic                               film_camera_state_out,
    output logic                               film_source_type_out,
    output logic                               film_phase_out,
    output logic                               global_motion_flag_out,
    output logic [fmd_pkg::STAT_W-1:0]         moving_block_statistic_out
);
    //--------------------------------------------------------------------------
    // Per-block activity
    //--------------------------------------------------------------------------
    logic                        term_valid;
    logic [fmd_pkg::VEC_W:0]     term;
    logic                        block_moving;

    activity_term u_term (
        .src_sel_in              (detect_source_select_in),
        .min_vector_threshold_in (min_vector_threshold_in),
        .vec_valid_in            (vec_valid_in),
        .vec_x_in                (vec_x_in),
        .vec_y_in                (vec_y_in),
        .fdiff_valid_in          (fdiff_valid_in),
        .fdiff_in                (fdiff_in),
        .term_valid_out          (term_valid),
        .term_out                (term),
        .block_moving_out        (block_moving)
    );

    //--------------------------------------------------------------------------
    // Field accumulation
    //--------------------------------------------------------------------------
    logic [fmd_pkg::SUM_W-1:0]   acc_ff;
    logic [fmd_pkg::STAT_W-1:0]  blk_cnt_ff;

    // Saturating sums; a block arriving with the field start opens the new field
    wire [fmd_pkg::SUM_W:0]      acc_add  = {1'b0, acc_ff} + {{(fmd_pkg::SUM_W-fmd_pkg::VEC_W){1'b0}}, term};
    wire [fmd_pkg::SUM_W-1:0]    acc_sat  = acc_add[fmd_pkg::SUM_W] ? '1 : acc_add[fmd_pkg::SUM_W-1:0];
    wire [fmd_pkg::SUM_W-1:0]    acc_base = field_start_in ? '0 : acc_ff;
    wire [fmd_pkg::SUM_W-1:0]    acc_base_add = field_start_in ?
                                     {{(fmd_pkg::SUM_W-fmd_pkg::VEC_W-1){1'b0}}, term} : acc_sat;
    wire [fmd_pkg::SUM_W-1:0]    nxt_acc  = term_valid ? acc_base_add : acc_base;
    wire [fmd_pkg::STAT_W-1:0]   blk_base = field_start_in ? '0 : blk_cnt_ff;
    wire                         blk_inc  = term_valid && block_moving && (blk_base != '1);
    wire [fmd_pkg::STAT_W-1:0]   nxt_blk  = blk_base + {{(fmd_pkg::STAT_W-1){1'b0}}, blk_inc};

    // Accumulators
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_ff     <= fmd_pkg::SUM_RST;
            blk_cnt_ff <= fmd_pkg::STAT_RST;
        end else begin
            acc_ff     <= nxt_acc;
            blk_cnt_ff <= nxt_blk;
        end
    end

    //--------------------------------------------------------------------------
    // Motion decision for the field that just ended
    //--------------------------------------------------------------------------
    logic                        mode_ff;
    // Bounds are scale times (threshold plus one), scale is 8 shifted by the code
    wire [3:0]                   lo_shift = fmd_pkg::SCALE_BASE_SHIFT + {2'h0, lower_scale_select_in};
    wire [3:0]                   hi_shift = fmd_pkg::SCALE_BASE_SHIFT + {2'h0, upper_scale_select_in};
    wire [fmd_pkg::BOUND_W-1:0]  lo_bound = ({8'h00, lower_motion_threshold_in} + 16'h0001) << lo_shift;
    wire [fmd_pkg::BOUND_W-1:0]  hi_bound = ({8'h00, upper_motion_threshold_in} + 16'h0001) << hi_shift;
    wire                         above_lo = acc_ff > {4'h0, lo_bound};
    wire                         above_hi = acc_ff > {4'h0, hi_bound};
    // Between the bounds the current mode decides, which is the hysteresis band
    wire                         in_band  = above_lo && !above_hi;
    wire                         moving   = above_hi || (in_band && (mode_ff == fmd_pkg::CAMERA_MODE));
    wire                         still    = !above_lo || (in_band && (mode_ff == fmd_pkg::FILM_MODE));

    //--------------------------------------------------------------------------
    // Mode switching with temporal hysteresis
    //--------------------------------------------------------------------------
    logic [1:0]                  hist_mot_ff;  // Motion of the two previous fields
    logic [fmd_pkg::HIST_CNT_W-1:0] hyst_cnt_ff;
    // Film: no two moving fields in a row, and motion within the last three fields
    wire                         film_like = !(moving && hist_mot_ff[0]) &&
                                             (moving || (|hist_mot_ff)) && !(hist_mot_ff == 2'h3);
    // Camera: motion in consecutive fields
    wire                         cam_like  = moving && hist_mot_ff[0];
    wire                         switch_ok = (mode_ff == fmd_pkg::CAMERA_MODE) ? film_like : cam_like;
    wire [fmd_pkg::HIST_CNT_W-1:0] need    = {1'b0, hysteresis_history_length_in, 1'b0} + 6'h02;
    wire [fmd_pkg::HIST_CNT_W-1:0] hyst_inc = hyst_cnt_ff + 6'h01;
    wire                         do_switch = switch_ok && (hyst_inc >= need);
    // A failing field restarts the count so only consecutive fields qualify
    wire [fmd_pkg::HIST_CNT_W-1:0] nxt_hyst = (!switch_ok || do_switch) ? '0 : hyst_inc;
    wire                         nxt_mode  = do_switch ? !mode_ff : mode_ff;

    //--------------------------------------------------------------------------
    // Film type and phase
    //--------------------------------------------------------------------------
    logic [1:0]                  still_run_ff;  // Still fields since last motion, saturating
    logic [1:0]                  prev_run_ff;
    logic                        type_ff;
    logic                        raw_phase_ff;
    // Gaps of two still fields only appear in 2-3 pulldown; steady single gaps mean 25 phases
    wire                         nxt_type  = !moving ? type_ff :
                                             (still_run_ff == 2'h2) ? 1'b1 :
                                             ((still_run_ff == 2'h1) && (prev_run_ff == 2'h1)) ? 1'b0 :
                                             type_ff;
    // New motion on a B field means that B pairs with the next A field
    wire                         nxt_raw_phase = (moving && (mode_ff == fmd_pkg::FILM_MODE)) ?
                                                 field_parity_in : raw_phase_ff;
    wire [1:0]                   nxt_run   = moving ? 2'h0 :
                                             (still_run_ff == 2'h3) ? 2'h3 : still_run_ff + 2'h1;

    //--------------------------------------------------------------------------
    // Global motion
    //--------------------------------------------------------------------------
    logic [fmd_pkg::STILL_CNT_W-1:0] still_cnt_ff;
    logic                        gmot_ff;
    wire [fmd_pkg::STILL_CNT_W-1:0] nxt_still = moving ? '0 :
                                   (still_cnt_ff == fmd_pkg::STILL_FIELDS) ? still_cnt_ff :
                                   still_cnt_ff + 6'h01;
    wire                         nxt_gmot  = (nxt_still != fmd_pkg::STILL_FIELDS);

    // Field-rate state, updated only on a field boundary
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_ff      <= fmd_pkg::MODE_RST;
            hist_mot_ff  <= 2'h0;
            hyst_cnt_ff  <= '0;
            still_run_ff <= 2'h0;
            prev_run_ff  <= 2'h0;
            type_ff      <= fmd_pkg::TYPE_RST;
            raw_phase_ff <= fmd_pkg::PHASE_RST;
            still_cnt_ff <= '0;
            gmot_ff      <= fmd_pkg::GMOT_RST;
        end else if (field_start_in) begin
            mode_ff      <= nxt_mode;
            hist_mot_ff  <= {hist_mot_ff[0], moving};
            hyst_cnt_ff  <= nxt_hyst;
            still_run_ff <= nxt_run;
            prev_run_ff  <= moving ? still_run_ff : prev_run_ff;
            type_ff      <= nxt_type;
            raw_phase_ff <= nxt_raw_phase;
            still_cnt_ff <= nxt_still;
            gmot_ff      <= nxt_gmot;
        end
    end

    //--------------------------------------------------------------------------
    // Reported results, captured at the field boundary
    //--------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            field_done_out             <= 1'b0;
            field_moving_out           <= 1'b0;
            vector_activity_sum_out    <= fmd_pkg::SUM_RST;
            moving_block_statistic_out <= fmd_pkg::STAT_RST;
        end else begin
            field_done_out <= field_start_in;
            if (field_start_in) begin
                field_moving_out           <= moving && !still;
                vector_activity_sum_out    <= acc_ff;
                moving_block_statistic_out <= blk_cnt_ff;
            end
        end
    end

    // Mode flags straight from field state; phase inversion applies to the reported phase only
    assign film_camera_state_out  = mode_ff;
    assign film_source_type_out   = type_ff;
    assign film_phase_out         = raw_phase_ff ^ phase_invert_in;
    assign global_motion_flag_out = gmot_ff;

    //--------------------------------------------------------------------------
    // Interpolation filter select and chroma vectors
    //--------------------------------------------------------------------------
    // The decode is registered so the upconverter sees a clean one-hot select
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            interp_improved_median_out <= 1'b0;
            interp_median_out          <= 1'b0;
            interp_intrafield_out      <= 1'b0;
            interp_interfield_out      <= 1'b1;
        end else begin
            interp_improved_median_out <= (interp_filter_select_in == fmd_pkg::FILT_IMPROVED);
            interp_median_out          <= (interp_filter_select_in == fmd_pkg::FILT_MEDIAN);
            interp_intrafield_out      <= (interp_filter_select_in == fmd_pkg::FILT_INTRA);
            interp_interfield_out      <= (interp_filter_select_in == fmd_pkg::FILT_INTER);
        end
    end

    // Chroma reuses the luminance vectors; no second estimator is spent on colour
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chroma_vec_valid_out <= 1'b0;
            chroma_vec_x_out     <= '0;
            chroma_vec_y_out     <= '0;
        end else begin
            chroma_vec_valid_out <= vec_valid_in;
            if (vec_valid_in) begin
                chroma_vec_x_out <= vec_x_in;
                chroma_vec_y_out <= vec_y_in;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/fmd_chk.sv]
// Assertion checker for the film mode and motion detector ports
`timescale 1ns/1ns
`default_nettype none
module fmd_chk (
    // Clock, reset and inputs
    input wire logic        ref_clk_in, rstn_in, field_start_in, vec_valid_in, phase_invert_in,
    input wire logic [7:0]  vec_x_in, vec_y_in, lower_motion_threshold_in, upper_motion_threshold_in,
    input wire logic [1:0]  lower_scale_select_in, upper_scale_select_in, interp_filter_select_in,
    // Outputs
    input wire logic        interp_improved_median_out, interp_median_out, interp_intrafield_out,
    input wire logic        interp_interfield_out, chroma_vec_valid_out, field_done_out,
    input wire logic        field_moving_out, film_camera_state_out, film_phase_out,
    input wire logic        global_motion_flag_out,
    input wire logic [7:0]  chroma_vec_x_out, chroma_vec_y_out,
    input wire logic [19:0] vector_activity_sum_out
);
    // Bounds: threshold plus one, times 8 shifted by the scale code
    wire logic [19:0] lo_b = (20'h1 + lower_motion_threshold_in) << ({2'h0, lower_scale_select_in} + 4'h3);
    wire logic [19:0] hi_b = (20'h1 + upper_motion_threshold_in) << ({2'h0, upper_scale_select_in} + 4'h3);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_done; field_start_in |=> field_done_out ##1 !field_done_out; endproperty
    a_done: assert property (p_done) else $error("field done pulse missing");
    property p_filt; 1 |=> {interp_improved_median_out, interp_median_out, interp_intrafield_out,
        interp_interfield_out} == 4'h1 << $past(interp_filter_select_in); endproperty
    a_filt: assert property (p_filt) else $error("filter decode wrong");
    property p_chroma; vec_valid_in |=> chroma_vec_valid_out && chroma_vec_x_out == $past(vec_x_in)
        && chroma_vec_y_out == $past(vec_y_in); endproperty
    a_chroma: assert property (p_chroma) else $error("chroma vector not reused");
    property p_phase; !field_done_out |-> film_phase_out ==
        ($past(film_phase_out) ^ phase_invert_in ^ $past(phase_invert_in)); endproperty
    a_phase: assert property (p_phase) else $error("phase inversion wrong");
    property p_mode; $changed(film_camera_state_out) |-> field_done_out; endproperty
    a_mode: assert property (p_mode) else $error("mode changed off boundary");
    property p_gm_set; field_done_out && field_moving_out |-> global_motion_flag_out; endproperty
    a_gm_set: assert property (p_gm_set) else $error("global motion not set");
    property p_gm_clr; $fell(global_motion_flag_out) |-> field_done_out && !field_moving_out;
    endproperty
    a_gm_clr: assert property (p_gm_clr) else $error("global motion cleared early");
    property p_mov; field_done_out && vector_activity_sum_out > hi_b |-> field_moving_out;
    endproperty
    a_mov: assert property (p_mov) else $error("field above bound not moving");
    property p_still; field_done_out && vector_activity_sum_out <= lo_b |-> !field_moving_out;
    endproperty
    a_still: assert property (p_still) else $error("field below bound moving");
    // Main scenarios reached
    c_film: cover property ($rose(film_camera_state_out));
    c_gm: cover property ($fell(global_motion_flag_out));
    c_mov: cover property (field_done_out && field_moving_out);
endmodule
bind film_mode_motion_detector fmd_chk chk (.*);
`default_nettype wire

// [tb/field_source.sv]
// Model of the upstream estimator: block samples and field pulses
`timescale 1ns/1ns
`default_nettype none
module field_source (
    // Clock
    input  wire logic       clk_in,
    // Field timing and samples
    output logic            field_start_out,
    output logic            parity_out,
    output logic            vec_valid_out,
    output logic [7:0]      vec_x_out,
    output logic [7:0]      vec_y_out,
    output logic            fdiff_valid_out,
    output logic [7:0]      fdiff_out
);
    initial begin
        {field_start_out, parity_out, vec_valid_out, fdiff_valid_out} = 4'h0;
        {vec_x_out, vec_y_out, fdiff_out} = 24'h0;
    end
    // Back to back samples, then a lone boundary pulse; stale payload goes inverted
    task automatic send_field(input int n, input logic [7:0] v, input logic [7:0] d);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            {vec_valid_out, fdiff_valid_out} <= 2'h3;
            vec_x_out <= v;
            vec_y_out <= -v;
            fdiff_out <= d;
        end
        @(posedge clk_in);
        {vec_valid_out, fdiff_valid_out} <= 2'h0;
        {vec_x_out, vec_y_out, fdiff_out} <= ~{vec_x_out, vec_y_out, fdiff_out};
        field_start_out <= 1'b1;
        @(posedge clk_in);
        field_start_out <= 1'b0;
        parity_out <= ~parity_out;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// [tb/film_mode_motion_detector_tb.sv]
// Self-checking bench for the film mode and motion detector
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch %0t %s", $time, m); end end
module film_mode_motion_detector_tb;
    //----------------------------------------
    // Stimulus and observation
    //----------------------------------------
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, inv = 1'b0, p;
    logic [7:0] thr = 8'h03, lth = 8'h00, uth = 8'h00;
    logic [1:0] lsc = 2'h0, usc = 2'h0, fsel = 2'h0;
    logic [3:0] hist = 4'h0, src = 4'h0;
    wire logic fs, par, vv, dv, imp, med, intra, inter, cvv, done, mov, mode, ftype, phase, gm;
    wire logic [7:0] vx, vy, fd, cx, cy, stat;
    wire logic [19:0] sum;
    int fail_count = 0, n_checks = 0, cyc = 0, e;
    // Row: blocks, vector component, scale code, filter code
    typedef struct packed { logic [7:0] n; logic [7:0] v; logic [1:0] sc; logic [1:0] fs; } row_t;
    row_t rows [7] = '{'{8'h01, 8'h05, 2'h0, 2'h3}, '{8'h01, 8'h03, 2'h0, 2'h2},
        '{8'h02, 8'h04, 2'h0, 2'h1}, '{8'h04, 8'h0a, 2'h2, 2'h0}, '{8'h01, 8'h10, 2'h3, 2'h1},
        '{8'h07, 8'h7f, 2'h3, 2'h3}, '{8'h01, 8'h08, 2'h1, 2'h2}};
    field_source src_m (.clk_in(ref_clk_in), .field_start_out(fs), .parity_out(par),
        .vec_valid_out(vv), .vec_x_out(vx), .vec_y_out(vy), .fdiff_valid_out(dv), .fdiff_out(fd));
    film_mode_motion_detector uut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .field_start_in(fs), .field_parity_in(par), .vec_valid_in(vv), .vec_x_in(vx),
        .vec_y_in(vy), .fdiff_valid_in(dv), .fdiff_in(fd), .min_vector_threshold_in(thr),
        .lower_motion_threshold_in(lth), .upper_motion_threshold_in(uth),
        .lower_scale_select_in(lsc), .upper_scale_select_in(usc),
        .hysteresis_history_length_in(hist), .detect_source_select_in(src),
        .phase_invert_in(inv), .interp_filter_select_in(fsel),
        .interp_improved_median_out(imp), .interp_median_out(med), .interp_intrafield_out(intra),
        .interp_interfield_out(inter), .chroma_vec_valid_out(cvv), .chroma_vec_x_out(cx),
        .chroma_vec_y_out(cy), .field_done_out(done), .field_moving_out(mov),
        .vector_activity_sum_out(sum), .film_camera_state_out(mode),
        .film_source_type_out(ftype), .film_phase_out(phase), .global_motion_flag_out(gm),
        .moving_block_statistic_out(stat));
    initial forever #25 ref_clk_in = ~ref_clk_in;
    // Cut a hang short; the whole run needs well under this many cycles
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            $display("mismatch %0t timeout", $time);
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset();
        rstn_in <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
    endtask
    //----------------------------------------
    // Main sequence
    //----------------------------------------
    initial begin
        do_reset();
        for (int i = 0; i < 7; i++) begin
            @(posedge ref_clk_in);
            {lsc, usc, fsel} <= {rows[i].sc, rows[i].sc, rows[i].fs};
            src_m.send_field(rows[i].n, rows[i].v, 8'h00);
            e = (rows[i].v > thr) ? rows[i].n * rows[i].v * 2 : 0;
            `CHK(sum, e[19:0], "activity sum")
            `CHK(mov, e > (32'h1 << (3 + rows[i].sc)), "field verdict")
            `CHK({imp, med, intra, inter}, 4'h1 << rows[i].fs, "filter decode")
            `CHK(stat, (e != 0) ? rows[i].n : 8'h00, "block count")
            $display("row %0d done", i);
        end
        {lsc, usc} <= 4'h0;
        do_reset();
        `CHK({gm, inter, mode, sum}, {3'h6, 20'h0}, "reset values")
        $display("reset test done");
        // Motion every second field is film material
        for (int i = 0; i < 6; i++) begin
            src_m.send_field(1, i[0] ? 8'h00 : 8'h05, 8'h00);
            if (i == 0) `CHK(mode, 1'b0, "early switch")
        end
        `CHK(mode, 1'b1, "film mode")
        `CHK(ftype, 1'b0, "film type")
        `CHK(phase, 1'b1, "film phase")
        p = phase;
        inv <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        `CHK(phase, ~p, "phase invert")
        inv <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            src_m.send_field(1, 8'h05, 8'h00);
            if (i == 1) `CHK(mode, 1'b1, "camera too soon")
        end
        `CHK(mode, 1'b0, "camera mode")
        $display("hysteresis test done");
        src <= 4'h1;
        src_m.send_field(1, 8'h05, 8'h14);
        `CHK({sum, stat}, {20'h14, 8'h01}, "difference source")
        src <= 4'hf;
        src_m.send_field(1, 8'h05, 8'h14);
        `CHK(stat, 8'h00, "least sensitive code")
        src <= 4'h0;
        $display("source test done");
        for (int i = 1; i <= 32; i++) begin
            src_m.send_field(0, 8'h00, 8'h00);
            if (i == 31) `CHK(gm, 1'b1, "global motion early clear")
        end
        `CHK(gm, 1'b0, "still scene")
        src_m.send_field(1, 8'h05, 8'h00);
        `CHK(gm, 1'b1, "motion again")
        // Two still fields between motion only happen with 2-3 pulldown
        repeat (2) src_m.send_field(0, 8'h00, 8'h00);
        src_m.send_field(1, 8'h05, 8'h00);
        `CHK(ftype, 1'b1, "pulldown type")
        $display("global motion test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
